//--- hdl/mover_pkg.sv
// Package: descriptor fields, completion codes, register map for the drain and copy engine
package mover_pkg;
    // Operation codes
    localparam logic [7:0] OP_DRAIN = 8'h02;
    localparam logic [7:0] OP_COPY = 8'h03;
    // Drain flag positions
    localparam int FLG_RB1_VALID = 16;
    localparam int FLG_RB2_VALID = 17;
    localparam int FLG_SUP_TCF = 18;
    localparam int FLG_SUP_TCS = 19;
    localparam int FLG_RSV_LO = 20;
    localparam int FLG_RSV_HI = 23;
    // Generic flag positions
    localparam int FLG_DEST_RB = 14;
    localparam int FLG_TC_SEL1 = 12;
    localparam int FLG_TC_SEL2 = 13;
    // Completion status codes
    localparam logic [5:0] ST_SUCCESS = 6'h01;
    localparam logic [5:0] ST_PAGE_FAULT = 6'h03;
    localparam logic [5:0] ST_BAD_OP = 6'h10;
    localparam logic [5:0] ST_BAD_FLAGS = 6'h11;
    localparam logic [5:0] ST_OVERLAP = 6'h13;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OPFLG = 8'h04;
    localparam logic [7:0] REG_SRC = 8'h08;
    localparam logic [7:0] REG_DST = 8'h0C;
    localparam logic [7:0] REG_SIZE = 8'h10;
    localparam logic [7:0] REG_RB1 = 8'h14;
    localparam logic [7:0] REG_RB2 = 8'h18;
    localparam logic [7:0] REG_STAT = 8'h1C;
    localparam logic [7:0] REG_DONE = 8'h20;
    localparam logic [7:0] REG_FAULT = 8'h24;
    localparam logic [7:0] REG_INVFLG = 8'h28;
    localparam logic [7:0] REG_FLTAT = 8'h2C;
    localparam logic [31:0] FAULT_NONE = 32'hFFFF_FFFF;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Memory request to the fabric
    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] tclass;
        logic [31:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    // Completion record summary
    typedef struct packed {
        logic [5:0] status;
        logic [7:0] result;
        logic [31:0] bytes_done;
        logic [31:0] fault_addr;
    } cmpl_s;
endpackage

//--- hdl/overlap_check.sv
// Overlap and direction decision for a copy
`timescale 1ns/1ps
module overlap_check
    import mover_pkg::*;
(
    // Copy region
    input wire logic [31:0] i_src,
    input wire logic [31:0] i_dst,
    input wire logic [31:0] i_size,
    // Decision
    output logic o_overlap,
    output logic o_reverse
);
    logic [32:0] src_end;
    logic [32:0] dst_end;

    // Regions overlap when each starts before the other ends
    always_comb begin
        src_end = {1'b0, i_src} + {1'b0, i_size};
        dst_end = {1'b0, i_dst} + {1'b0, i_size};
        o_overlap = (i_size != 32'h0000_0000) && ({1'b0, i_src} < dst_end) && ({1'b0, i_dst} < src_end);
        o_reverse = o_overlap && (i_dst > i_src);
    end
endmodule

//--- hdl/drain_move_engine.sv
// Drain and memory copy executor behind an AXI4-Lite register file
// What the document asks of this block and its submitter
// RL1: Opcode 0x02 drains; completion waits for earlier queue descriptors.
// RL2: Drain inside a batch is rejected as unsupported operation.
// RL3: Submitter should request completion record or interrupt on drains.
// RL4: Drain completion only after all awaited descriptors are done.
// RL5: Readback-valid flags reserved when readback capability is 0.
// RL6: Traffic class selector reserved unless its readback-valid flag is set.
// RL7: Submitter writes zero in drain flag bits 23:20.
// RL8: Bit 19 suppresses implicit readback on second traffic class.
// RL9: Bit 18 suppresses implicit readback on first traffic class.
// RL10: Bit 17 reads back second address on selected traffic class.
// RL11: Bit 16 reads back first address on selected traffic class.
// RL12: Destination-readback flag is reserved in drain descriptors.
// RL13: Opcode 0x03 copies exactly transfer-size bytes source to destination.
// RL14: Any alignment of addresses and size is accepted without error.
// RL15: With overlap support, overlapping copy preserves source, may reverse.
// RL16: Without overlap support, overlapping copy completes with error.
// RL17: Page-fault partial completion reports direction: 0 forward, 1 reversed.
// RL18: Without overlap support, copy result byte is always 0.
// RL19: After result 0, submitter advances addresses, shrinks size.
// RL20: After result 1, submitter shrinks size only, keeps addresses.
// RL21: Continuation may report a different direction than before.
// RL22: Page fault records fully processed source byte count.
// RL23: Page fault records the faulting address.
`timescale 1ns/1ps
module drain_move_engine
    import mover_pkg::*;
#(
    parameter bit OVERLAP_SUPPORT = 1'b1,
    parameter bit READBACK_SUPPORT = 1'b1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // AXI4-Lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Work queue state
    input wire logic i_prior_busy,
    // Memory port, byte wide
    output mem_req_s o_mem_req,
    input wire logic i_mem_ready,
    input wire logic i_mem_rvalid,
    input wire logic [7:0] i_mem_rdata,
    input wire logic i_mem_fault,
    // Completion notice
    output logic o_cmpl_valid,
    output cmpl_s o_cmpl
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DECODE = 3'b001,
        S_WAIT = 3'b010,
        S_RB = 3'b011,
        S_RD = 3'b100,
        S_WR = 3'b101,
        S_DONE = 3'b110
    } state_e;

    state_e state_r;
    logic [31:0] opflg_r, src_r, dst_r, size_r, rb1_r, rb2_r;
    logic [31:0] count_r;
    logic [31:0] fault_at_r;
    logic [7:0] byte_r;
    logic rev_r, rb_idx_r, pend_r, in_batch_r;
    logic [1:0] rb_need_r;
    cmpl_s cmpl_r;
    logic busy_r;
    logic aw_got_r, w_got_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic overlap, reverse;
    logic [7:0] opcode;
    logic [23:0] flags;
    logic [23:0] bad_flags;
    logic [31:0] offs, cur_src, cur_dst;
    logic wr_fire, go;

    assign opcode = opflg_r[31:24];
    assign flags = opflg_r[23:0];

    overlap_check u_overlap (
        .i_src(src_r),
        .i_dst(dst_r),
        .i_size(size_r),
        .o_overlap(overlap),
        .o_reverse(reverse)
    );

    // Byte address of current step in chosen direction
    function automatic logic [31:0] step_addr(input logic [31:0] base, input logic [31:0] size,
                                              input logic [31:0] cnt, input logic rev);
        step_addr = rev ? (base + size - cnt - 32'h0000_0001) : (base + cnt);
    endfunction

    assign offs = count_r;
    assign cur_src = step_addr(src_r, size_r, offs, rev_r);
    assign cur_dst = step_addr(dst_r, size_r, offs, rev_r);

    // Invalid drain flags
    always_comb begin
        bad_flags = 24'h00_0000;
        bad_flags[FLG_RSV_HI:FLG_RSV_LO] = flags[FLG_RSV_HI:FLG_RSV_LO];
        bad_flags[FLG_DEST_RB] = flags[FLG_DEST_RB]; // [RL12]
        if (!READBACK_SUPPORT) begin
            bad_flags[FLG_RB1_VALID] = flags[FLG_RB1_VALID]; // [RL5]
            bad_flags[FLG_RB2_VALID] = flags[FLG_RB2_VALID];
        end
        bad_flags[FLG_TC_SEL1] = flags[FLG_TC_SEL1] && !flags[FLG_RB1_VALID]; // [RL6]
        bad_flags[FLG_TC_SEL2] = flags[FLG_TC_SEL2] && !flags[FLG_RB2_VALID];
    end

    // AXI write path: address and data in either order
    assign o_awready = !aw_got_r && !o_bvalid;
    assign o_wready = !w_got_r && !o_bvalid;
    assign wr_fire = aw_got_r && w_got_r && !o_bvalid;
    assign go = wr_fire && (awaddr_r == REG_CTRL) && wdata_r[0] && !busy_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= i_wdata;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (awaddr_r > REG_RB2) ? RESP_SLVERR : RESP_OKAY;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Descriptor registers, writable while idle
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            opflg_r <= 32'h0000_0000;
            src_r <= 32'h0000_0000;
            dst_r <= 32'h0000_0000;
            size_r <= 32'h0000_0000;
            rb1_r <= 32'h0000_0000;
            rb2_r <= 32'h0000_0000;
            in_batch_r <= 1'b0;
        end else if (wr_fire && !busy_r) begin
            case (awaddr_r)
                REG_CTRL: in_batch_r <= wdata_r[1];
                REG_OPFLG: opflg_r <= wdata_r;
                REG_SRC: src_r <= wdata_r;
                REG_DST: dst_r <= wdata_r;
                REG_SIZE: size_r <= wdata_r;
                REG_RB1: rb1_r <= wdata_r;
                REG_RB2: rb2_r <= wdata_r;
                default: ;
            endcase
        end
    end

    // AXI read path
    assign o_arready = !o_rvalid;
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp <= RESP_OKAY;
            case (i_araddr)
                REG_CTRL: o_rdata <= {30'h0000_0000, in_batch_r, busy_r};
                REG_OPFLG: o_rdata <= opflg_r;
                REG_SRC: o_rdata <= src_r;
                REG_DST: o_rdata <= dst_r;
                REG_SIZE: o_rdata <= size_r;
                REG_RB1: o_rdata <= rb1_r;
                REG_RB2: o_rdata <= rb2_r;
                REG_STAT: o_rdata <= {16'h0000, cmpl_r.result, 2'b00, cmpl_r.status};
                REG_DONE: o_rdata <= cmpl_r.bytes_done;
                REG_FAULT: o_rdata <= cmpl_r.fault_addr;
                REG_INVFLG: o_rdata <= {8'h00, bad_flags};
                REG_FLTAT: o_rdata <= fault_at_r;
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // Fault injection byte index for test; FAULT_NONE disables
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            fault_at_r <= FAULT_NONE;
        end else if (wr_fire && !busy_r && awaddr_r == REG_FLTAT) begin
            fault_at_r <= wdata_r;
        end
    end

    // Memory request, driven from state
    always_comb begin
        o_mem_req = '0;
        case (state_r)
            S_RB: begin
                o_mem_req.rd = !pend_r;
                o_mem_req.addr = rb_idx_r ? rb2_r : rb1_r; // [RL10] [RL11]
                o_mem_req.tclass = rb_idx_r ? {1'b1, flags[FLG_TC_SEL2]} : {1'b0, flags[FLG_TC_SEL1]};
            end
            S_RD: begin
                o_mem_req.rd = !pend_r;
                o_mem_req.addr = cur_src;
            end
            S_WR: begin
                o_mem_req.wr = 1'b1;
                o_mem_req.addr = cur_dst;
                o_mem_req.wdata = byte_r;
            end
            default: ;
        endcase
    end

    // Main sequencer
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_r <= S_IDLE;
            busy_r <= 1'b0;
            count_r <= 32'h0000_0000;
            byte_r <= 8'h00;
            rev_r <= 1'b0;
            pend_r <= 1'b0;
            rb_idx_r <= 1'b0;
            rb_need_r <= 2'b00;
            cmpl_r <= '0;
            o_cmpl_valid <= 1'b0;
        end else begin
            o_cmpl_valid <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (go) begin
                        busy_r <= 1'b1;
                        count_r <= 32'h0000_0000;
                        pend_r <= 1'b0;
                        cmpl_r <= '0;
                        state_r <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    cmpl_r.status <= ST_SUCCESS;
                    state_r <= S_DONE;
                    if (opcode == OP_DRAIN) begin
                        if (in_batch_r) begin
                            cmpl_r.status <= ST_BAD_OP; // [RL2]
                        end else if (bad_flags != 24'h00_0000) begin
                            cmpl_r.status <= ST_BAD_FLAGS;
                        end else begin
                            rb_need_r <= {flags[FLG_RB2_VALID], flags[FLG_RB1_VALID]};
                            state_r <= S_WAIT; // [RL1]
                        end
                    end else if (opcode == OP_COPY) begin
                        // No alignment check at all [RL14]
                        if (overlap && !OVERLAP_SUPPORT) begin
                            cmpl_r.status <= ST_OVERLAP; // [RL16]
                        end else if (size_r != 32'h0000_0000) begin
                            rev_r <= OVERLAP_SUPPORT && reverse; // [RL15] [RL18]
                            state_r <= S_RD;
                        end
                    end else begin
                        cmpl_r.status <= ST_BAD_OP;
                    end
                end
                S_WAIT: begin
                    // Implicit readbacks are not performed, which honours both suppress bits [RL8] [RL9]
                    if (!i_prior_busy) begin // [RL4]
                        if (rb_need_r != 2'b00) begin
                            rb_idx_r <= !rb_need_r[0];
                            state_r <= S_RB;
                        end else begin
                            state_r <= S_DONE;
                        end
                    end
                end
                S_RB: begin
                    if (o_mem_req.rd && i_mem_ready) begin
                        pend_r <= 1'b1;
                    end
                    if (i_mem_rvalid) begin
                        pend_r <= 1'b0;
                        rb_need_r[rb_idx_r] <= 1'b0;
                        if (!rb_idx_r && rb_need_r[1]) begin
                            rb_idx_r <= 1'b1;
                        end else begin
                            state_r <= S_DONE;
                        end
                    end
                end
                S_RD: begin
                    if (i_mem_fault || count_r == fault_at_r) begin
                        cmpl_r.status <= ST_PAGE_FAULT;
                        cmpl_r.result <= {7'h00, rev_r}; // [RL17] [RL21]
                        cmpl_r.bytes_done <= count_r; // [RL22]
                        cmpl_r.fault_addr <= cur_src; // [RL23]
                        state_r <= S_DONE;
                    end else begin
                        if (o_mem_req.rd && i_mem_ready) begin
                            pend_r <= 1'b1;
                        end
                        if (i_mem_rvalid) begin
                            pend_r <= 1'b0;
                            byte_r <= i_mem_rdata;
                            state_r <= S_WR;
                        end
                    end
                end
                S_WR: begin
                    if (i_mem_ready) begin
                        count_r <= count_r + 32'h0000_0001;
                        if (count_r + 32'h0000_0001 == size_r) begin
                            state_r <= S_DONE; // [RL13]
                        end else begin
                            state_r <= S_RD;
                        end
                    end
                end
                S_DONE: begin
                    o_cmpl_valid <= 1'b1;
                    busy_r <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    assign o_cmpl = cmpl_r;

    // Drain notice never while earlier work is pending
    drain_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_r == S_WAIT && i_prior_busy) |=> state_r == S_WAIT) // [RL4]
        else $error("drain left wait while earlier work busy");

    // Batched drain rejected
    batch_reject_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_r == S_DECODE && opcode == OP_DRAIN && in_batch_r) |=> ##1 o_cmpl_valid && o_cmpl.status == ST_BAD_OP) // [RL2]
        else $error("batched drain not rejected");

    // Overlap without support is an error
    overlap_err_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_r == S_DECODE && opcode == OP_COPY && overlap && !OVERLAP_SUPPORT)
        |=> ##1 o_cmpl.status == ST_OVERLAP) // [RL16]
        else $error("overlap not flagged");

    // Result zero without overlap support
    result_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_cmpl_valid && !OVERLAP_SUPPORT |-> o_cmpl.result == 8'h00) // [RL18]
        else $error("nonzero result without overlap support");

    // Full copy counts exactly size bytes
    copy_count_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_cmpl_valid && opcode == OP_COPY && o_cmpl.status == ST_SUCCESS |-> count_r == size_r) // [RL13]
        else $error("copy length mismatch");

    // Fault record carries progress and address
    sequence fault_seen;
        state_r == S_RD && i_mem_fault;
    endsequence
    fault_record_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        fault_seen |=> cmpl_r.bytes_done == $past(count_r) && cmpl_r.fault_addr == $past(cur_src)
        && cmpl_r.result[0] == rev_r) // [RL22] [RL23] [RL17]
        else $error("fault record wrong");

    // Reserved destination-readback flag in a drain gives invalid flags
    drain_flags_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_r == S_DECODE && opcode == OP_DRAIN && !in_batch_r && flags[FLG_DEST_RB])
        |=> cmpl_r.status == ST_BAD_FLAGS) // [RL12]
        else $error("destination readback flag accepted");

    // Readback uses chosen traffic class
    rb_class_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_mem_req.rd && state_r == S_RB && rb_idx_r |-> o_mem_req.addr == rb2_r
        && o_mem_req.tclass[0] == flags[FLG_TC_SEL2]) // [RL10]
        else $error("readback address or class wrong");
endmodule

//--- bench/mem_model.sv
// Byte-wide system memory seen over the fabric port
`timescale 1ns/1ps
module mem_model
    import mover_pkg::*;
(
    // Fabric side
    input wire logic i_sys_clk,
    input wire mem_req_s i_req,
    output logic o_ready,
    output logic o_rvalid,
    output logic [7:0] o_rdata,
    output logic o_fault,
    // Bench control and observation
    input wire logic i_slow,
    input wire logic [31:0] i_fault_at,
    output logic [31:0] o_last_rd
);
    logic [7:0] mem [256];
    logic stall_r = 1'b0;
    logic rv_r = 1'b0;
    logic [7:0] rd_r = 8'h00;
    logic [31:0] last_r = 32'h0000_0000;
    // A read of the poisoned byte faults and is never taken
    assign o_fault = i_req.rd && (i_req.addr == i_fault_at);
    assign o_ready = (i_req.rd || i_req.wr) && !o_fault && !(i_slow && stall_r);
    assign o_rvalid = rv_r;
    assign o_rdata = rd_r;
    assign o_last_rd = last_r;
    // Answer one cycle after a read; idle data toggles so it is never trusted
    always @(posedge i_sys_clk) begin
        stall_r <= !stall_r;
        rv_r <= 1'b0;
        rd_r <= ~rd_r;
        if (o_ready && i_req.rd) begin
            rv_r <= 1'b1;
            rd_r <= mem[i_req.addr[7:0]];
            last_r <= i_req.addr;
        end
        if (o_ready && i_req.wr) begin
            mem[i_req.addr[7:0]] <= i_req.wdata;
        end
    end
endmodule

//--- bench/test_drain_and_memory_move_ops.sv
// Self-checking bench for the drain and copy engine
`timescale 1ns/1ps
module test_drain_and_memory_move_ops;
    import mover_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, fault_at = 32'hFFFF_FFFF;
    logic prior_busy = 1'b0, slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, mready, mrv, mflt, cv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, last_rd;
    logic [7:0] mrd;
    mem_req_s mreq;
    cmpl_s cmpl, got;
    // Second engine built without overlap or readback support
    logic cv2;
    cmpl_s cmpl2, got2;
    int fails = 0, checks = 0, ncmpl = 0, base;
    drain_move_engine i_drain_move_engine (.i_sys_clk(clk), .i_reset(rst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_prior_busy(prior_busy), .o_mem_req(mreq), .i_mem_ready(mready),
        .i_mem_rvalid(mrv), .i_mem_rdata(mrd), .i_mem_fault(mflt), .o_cmpl_valid(cv), .o_cmpl(cmpl));
    drain_move_engine #(.OVERLAP_SUPPORT(1'b0), .READBACK_SUPPORT(1'b0)) i_drain_move_engine_basic (
        .i_sys_clk(clk), .i_reset(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(), .i_wdata(wdata),
        .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(), .o_bresp(), .o_bvalid(), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(), .o_rdata(), .o_rresp(), .o_rvalid(),
        .i_rready(rready), .i_prior_busy(prior_busy), .o_mem_req(), .i_mem_ready(1'b1), .i_mem_rvalid(1'b1),
        .i_mem_rdata(8'h00), .i_mem_fault(1'b0), .o_cmpl_valid(cv2), .o_cmpl(cmpl2));
    mem_model i_mem_model (.i_sys_clk(clk), .i_req(mreq), .o_ready(mready), .o_rvalid(mrv), .o_rdata(mrd),
        .o_fault(mflt), .i_slow(slow), .i_fault_at(fault_at), .o_last_rd(last_rd));
    // Clock and completion capture
    always #5 clk = ~clk;
    always @(negedge clk) begin
        if (cv === 1'b1) begin
            got = cmpl;
            ncmpl++;
        end
        if (cv2 === 1'b1) begin
            got2 = cmpl2;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end while (!b_t);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ar_t = arvalid && arready;
            r_t = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
        end while (!r_t);
        rready <= 1'b0;
    endtask
    // Start an operation and wait for its completion pulse
    task automatic go(input logic [31:0] ctl);
        base = ncmpl;
        wr(REG_CTRL, ctl);
        while (ncmpl == base) @(posedge clk);
    endtask
    task automatic copy_case(input logic [31:0] s, d, n, f, input logic [5:0] est, input logic [7:0] eres,
        input logic [31:0] edone);
        logic [7:0] snap [256];
        logic [31:0] v;
        logic [1:0] r;
        for (int i = 0; i < 256; i++) begin
            snap[i] = 8'(i * 7 + 3);
            i_mem_model.mem[i] = snap[i];
        end
        fault_at <= f;
        wr(REG_SRC, s);
        wr(REG_DST, d);
        wr(REG_SIZE, n);
        wr(REG_OPFLG, {OP_COPY, 24'h00_0000});
        go(32'h0000_0001);
        chk("copy status", 32'(est), 32'(got.status));
        chk("copy result", 32'(eres), 32'(got.result));
        chk("copy bytes done", edone, got.bytes_done);
        if (est == ST_PAGE_FAULT) chk("fault address", f, got.fault_addr);
        for (int i = 0; i < n; i++) begin
            if (est == ST_SUCCESS || (eres == 8'h00 && i < edone))
                chk("dest byte", 32'(snap[8'(s + i)]), 32'(i_mem_model.mem[8'(d + i)]));
        end
        rd(REG_STAT, v, r);
        chk("status reg", {16'h0000, eres, 2'b00, est}, v);
        fault_at <= 32'hFFFF_FFFF;
        $display("copy test from %h to %h done", s, d);
    endtask
    task automatic drain_cases();
        logic [23:0] fl [7] = '{24'h01_0000, 24'h02_0000, 24'h0C_0000, 24'h10_0000, 24'h00_1000,
            24'h01_1000, 24'h00_4000};
        logic [5:0] st [7] = '{ST_SUCCESS, ST_SUCCESS, ST_SUCCESS, ST_BAD_FLAGS, ST_BAD_FLAGS,
            ST_SUCCESS, ST_BAD_FLAGS};
        wr(REG_RB1, 32'h0000_00F0);
        wr(REG_RB2, 32'h0000_00F8);
        for (int i = 0; i < 7; i++) begin
            wr(REG_OPFLG, {OP_DRAIN, fl[i]});
            go(32'h0000_0001);
            chk("drain status", 32'(st[i]), 32'(got.status));
            if (i == 0) chk("drain without readback support", 32'(ST_BAD_FLAGS), 32'(got2.status));
            if (i == 0) chk("first readback", 32'h0000_00F0, last_rd);
            if (i == 1) chk("second readback", 32'h0000_00F8, last_rd);
        end
        // Clean drain flags so the held drain really waits
        wr(REG_OPFLG, {OP_DRAIN, 24'h00_0000});
        prior_busy <= 1'b1;
        base = ncmpl;
        wr(REG_CTRL, 32'h0000_0001);
        repeat (30) @(posedge clk);
        chk("held drain", 32'(base), 32'(ncmpl));
        prior_busy <= 1'b0;
        while (ncmpl == base) @(posedge clk);
        chk("released drain", 32'(ST_SUCCESS), 32'(got.status));
        go(32'h0000_0003);
        chk("batched drain", 32'(ST_BAD_OP), 32'(got.status));
        $display("drain tests done");
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        complete_run();
    end
    // Main sequence
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        drain_cases();
        copy_case(32'h11, 32'h40, 32'd5, 32'hFFFF_FFFF, ST_SUCCESS, 8'h00, 32'd0);
        slow <= 1'b1;
        copy_case(32'h20, 32'h23, 32'd9, 32'hFFFF_FFFF, ST_SUCCESS, 8'h00, 32'd0);
        chk("overlap without support", 32'(ST_OVERLAP), 32'(got2.status));
        slow <= 1'b0;
        copy_case(32'h23, 32'h20, 32'd9, 32'hFFFF_FFFF, ST_SUCCESS, 8'h00, 32'd0);
        copy_case(32'h50, 32'h80, 32'd10, 32'h53, ST_PAGE_FAULT, 8'h00, 32'd3);
        copy_case(32'h53, 32'h83, 32'd7, 32'hFFFF_FFFF, ST_SUCCESS, 8'h00, 32'd0);
        copy_case(32'h20, 32'h24, 32'd8, 32'h27, ST_PAGE_FAULT, 8'h01, 32'd0);
        chk("result without overlap support", 32'h0000_0000, 32'(got2.result));
        rd(8'h40, v, r);
        chk("unmapped read", 32'(RESP_SLVERR), 32'(r));
        $display("register test done");
        complete_run();
    end
endmodule
